/* File: design/spsc_top.sv */
// Serial interface: parity, status flags, interrupts, low power, clock output
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module spsc_top import spsc_pkg::*; (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rxd_pin,
  output logic             txd_out,
  output logic             txd_oe_n,
  output logic             sclk_out,
  output logic             sclk_oe_n,
  input  wire logic        irq_mask,
  input  wire logic        halt_mode,
  input  wire logic        wait_mode,
  output logic             irq,
  output logic             wake_req,
  output logic             addr_mark
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ===========================================================================
  // Register state
  logic [7:0]  stat, c1, c2, c3, tx_buffer, rx_buffer;
  logic [15:0] baud;
  logic        stat_seen, dp_wr, wclr_pend;
  logic [7:0]  dp_addr;
  logic [7:0]  set_v, clr_v, next_stat;
  spsc_cfg_t   cur_cfg;
  logic        run;

  // Halt freezes register writes, status, sequencers and pins; bus capture, rx sync and irq run on
  assign run     = !halt_mode;
  assign cur_cfg = '{word_long: c1[C1_LONG], par_en: c1[C1_PEN], par_odd: c1[C1_ODD]};

  // ===========================================================================
  // AHB-Lite decode
  logic ap, ap_stat, ap_data, rd_clr, wr_clr;
  logic [7:0] rd_mux;
  assign ap      = hsel & htrans[1] & hready;
  assign ap_stat = ap & (haddr[7:0] == OFF_STATUS);
  assign ap_data = ap & (haddr[7:0] == OFF_DATA);
  assign rd_clr  = run & ap_data & !hwrite & stat_seen;
  assign wr_clr  = run & dp_wr & (dp_addr == OFF_DATA) & wclr_pend;
  assign rd_mux  = (haddr[7:0] == OFF_STATUS) ? stat :
                   (haddr[7:0] == OFF_DATA)   ? rx_buffer :
                   (haddr[7:0] == OFF_CTRL1)  ? c1 :
                   (haddr[7:0] == OFF_CTRL2)  ? c2 :
                   (haddr[7:0] == OFF_CTRL3)  ? {4'h0, c3[3:0]} : 8'h00;

  // Address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr     <= 1'b0;
      dp_addr   <= 8'h00;
      wclr_pend <= 1'b0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      dp_wr     <= ap & hwrite;
      dp_addr   <= haddr[7:0];
      wclr_pend <= ap_data & hwrite & stat_seen;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ap & !hwrite) begin
        hrdata <= (haddr[7:0] == OFF_BAUD) ? {16'h0000, baud} : {24'h00_0000, rd_mux};
      end
    end
  end

  // Status access arms the clear; the next data access consumes it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_seen <= 1'b0;
    end else if (run && ap_stat) begin
      stat_seen <= 1'b1;
    end else if (run && ap_data) begin
      stat_seen <= 1'b0;
    end
  end

  // Control register writes, ignored while halted
  logic rx_b8_set;
  logic rx_b8;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c1 <= CTRL_RST;
      c2 <= CTRL_RST;
      c3 <= CTRL_RST;
      baud <= BAUD_RST;
      tx_buffer <= 8'h00;
    end else begin
      if (rx_b8_set) begin
        c1[C1_RXB8] <= rx_b8;
      end
      if (run && dp_wr) begin
        if (dp_addr == OFF_CTRL1) begin
          c1[6:0] <= hwdata[6:0];
        end
        if (dp_addr == OFF_CTRL2) begin
          c2 <= hwdata[7:0];
        end
        if (dp_addr == OFF_CTRL3) begin
          c3 <= {4'h0, hwdata[3:0]};
        end
        if (dp_addr == OFF_BAUD) begin
          baud <= hwdata[15:0];
        end
        if (dp_addr == OFF_DATA) begin
          tx_buffer <= hwdata[7:0];
        end
      end
    end
  end

  // ===========================================================================
  // Transmitter
  spsc_tx_t   tx_state;
  spsc_cfg_t  tx_cfg;
  logic [8:0] tx_sh, tx_word;
  logic [3:0] tx_bit, tx_n;
  logic [15:0] tcnt;
  logic       tx_tick, tx_first, te_q, pre_pend, tx_isdata, tx_load, tx_end;
  logic       tx_par, pulse_en, next_sclk, next_txd;
  assign tx_n     = spsc_nbits(tx_cfg);
  assign tx_tick  = run & (tcnt == baud - 16'h0001);
  assign tx_first = tcnt < {1'b0, baud[15:1]};
  assign tx_par   = spsc_par({c1[C1_TXB8], tx_buffer}, cur_cfg);
  // Parity takes the place of the top data bit
  assign tx_word  = !cur_cfg.par_en ? {c1[C1_TXB8], tx_buffer} :
                    cur_cfg.word_long ? {tx_par, tx_buffer} :
                    {1'b0, tx_par, tx_buffer[6:0]};
  assign tx_load  = run & (tx_state == TX_IDLE) & c2[C2_TE] & !pre_pend &
                    !c2[C2_SBK] & !stat[ST_TXE];
  assign tx_end   = tx_tick & (tx_state == TX_STOP);

  // Frame sequencer; config latched at load so changes wait for the next byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state <= TX_IDLE;
      tx_cfg <= '0;
      tx_sh <= 9'h000;
      tx_bit <= 4'h0;
      tcnt <= 16'h0000;
      te_q <= 1'b0;
      pre_pend <= 1'b0;
      tx_isdata <= 1'b0;
    end else if (run) begin
      te_q <= c2[C2_TE];
      tcnt <= (tx_state == TX_IDLE || tx_tick) ? 16'h0000 : tcnt + 16'h0001;
      if (c2[C2_TE] && !te_q) begin
        pre_pend <= 1'b1;
      end
      unique case (tx_state)
        TX_IDLE: begin
          tx_bit <= 4'h0;
          tx_cfg <= cur_cfg;
          if (c2[C2_TE] && pre_pend) begin
            pre_pend <= 1'b0;
            tx_state <= TX_PRE;
          end else if (c2[C2_TE] && c2[C2_SBK]) begin
            tx_state <= TX_BRK;
          end else if (tx_load) begin
            tx_sh <= tx_word;
            tx_isdata <= 1'b1;
            tx_state <= TX_START;
          end
        end
        TX_PRE, TX_BRK: begin
          if (tx_tick) begin
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == tx_n + 4'h1) begin
              tx_isdata <= 1'b0;
              tx_state <= (tx_state == TX_BRK) ? TX_STOP : TX_IDLE;
            end
          end
        end
        TX_START: begin
          if (tx_tick) begin
            tx_state <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_tick) begin
            tx_sh <= {1'b0, tx_sh[8:1]};
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == tx_n - 4'h1) begin
              tx_state <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (tx_tick) begin
            tx_state <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // Clock pulses only in data bits, last one optional, shaped by polarity/phase
  assign pulse_en  = (tx_state == TX_DATA) &
                     ((tx_bit != tx_n - 4'h1) | c3[C3_LAST]);
  assign next_sclk = c3[C3_POL] ^ (pulse_en & (c3[C3_PHA] ? tx_first : !tx_first));
  assign next_txd  = (tx_state == TX_DATA) ? tx_sh[0] :
                     !((tx_state == TX_START) | (tx_state == TX_BRK));

  // Pin drivers; both enables off floats both pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_out <= 1'b1;
      sclk_out <= 1'b0;
      txd_oe_n <= 1'b1;
      sclk_oe_n <= 1'b1;
    end else if (run) begin
      txd_out <= next_txd;
      sclk_out <= next_sclk;
      txd_oe_n <= !(c2[C2_TE] | c2[C2_RE]);
      sclk_oe_n <= !(c3[C3_CKEN] & (c2[C2_TE] | c2[C2_RE]));
    end
  end

  // ===========================================================================
  // Receiver: two-stage sync, three-sample vote at mid-bit
  spsc_rx_t   rx_state;
  spsc_cfg_t  rx_cfg;
  logic       rx_s1, rx_s2, maj, noisy, rx_noise, rx_mid, rx_wrap, rx_done;
  logic [2:0] rx_hist;
  logic [8:0] rx_sh;
  logic [3:0] rx_bit, rx_n, idle_cnt;
  logic [15:0] rcnt;
  logic       idle_armed, rx_fail, rx_fe;
  assign rx_n    = spsc_nbits(rx_cfg);
  assign maj     = (rx_hist[0] & rx_hist[1]) | (rx_hist[0] & rx_hist[2]) |
                   (rx_hist[1] & rx_hist[2]);
  assign noisy   = !(&rx_hist) & (|rx_hist);
  assign rx_mid  = run & (rcnt == {1'b0, baud[15:1]});
  assign rx_wrap = run & (rcnt == baud - 16'h0001);
  assign rx_done = rx_mid & (rx_state == RX_STOP);
  assign rx_fe   = !maj;
  assign rx_fail = rx_cfg.par_en &
                   (spsc_par(rx_sh, rx_cfg) != rx_sh[rx_n - 4'h1]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_hist <= 3'h7;
    end else begin
      rx_s1 <= rxd_pin;
      rx_s2 <= rx_s1;
      rx_hist <= {rx_hist[1:0], rx_s2};
    end
  end

  // Frame sampler; config latched at start edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= RX_IDLE;
      rx_cfg <= '0;
      rx_sh <= 9'h000;
      rx_bit <= 4'h0;
      rcnt <= 16'h0000;
      rx_noise <= 1'b0;
    end else if (run) begin
      rcnt <= rx_wrap ? 16'h0000 : rcnt + 16'h0001;
      unique case (rx_state)
        RX_IDLE: begin
          if (c2[C2_RE] && !rx_s2) begin
            rcnt <= 16'h0000;
            rx_cfg <= cur_cfg;
            rx_noise <= 1'b0;
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_mid) begin
            rx_bit <= 4'h0;
            rx_noise <= noisy;
            rx_state <= maj ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_sh[rx_bit] <= maj;
            rx_noise <= rx_noise | noisy;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == rx_n - 4'h1) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Buffer transfer, blocked while the previous word is unread
  assign rx_b8_set = rx_done & !stat[ST_RXR] & rx_cfg.word_long;
  assign rx_b8     = rx_sh[8];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buffer <= 8'h00;
      addr_mark <= 1'b0;
    end else if (rx_done && !stat[ST_RXR]) begin
      rx_buffer <= rx_sh[7:0];
      addr_mark <= rx_sh[rx_n - 4'h1 - {3'h0, rx_cfg.par_en}];
    end
  end

  // Idle line: one frame of high line after a reception
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt <= 4'h0;
      idle_armed <= 1'b0;
    end else if (run) begin
      if (rx_state != RX_IDLE || !rx_s2 || !c2[C2_RE]) begin
        idle_cnt <= 4'h0;
      end else if (rx_wrap && idle_cnt != 4'hf) begin
        idle_cnt <= idle_cnt + 4'h1;
      end
      if (set_v[ST_RXR]) begin
        idle_armed <= 1'b1;
      end else if (set_v[ST_IDLE]) begin
        idle_armed <= 1'b0;
      end
    end
  end

  // ===========================================================================
  // Status flags: hardware set wins over the software clear
  assign set_v[ST_TXE]  = tx_load;
  assign set_v[ST_TC]   = tx_end & tx_isdata;
  assign set_v[ST_RXR]  = rx_done & !stat[ST_RXR];
  assign set_v[ST_IDLE] = idle_armed & (idle_cnt == rx_n + 4'h2) & rx_wrap;
  assign set_v[ST_OVR]  = rx_done & stat[ST_RXR];
  assign set_v[ST_NF]   = set_v[ST_RXR] & rx_noise;
  assign set_v[ST_FE]   = set_v[ST_RXR] & rx_fe;
  assign set_v[ST_PE]   = set_v[ST_RXR] & rx_fail;
  assign clr_v = (rd_clr ? RX_CLR_MASK : 8'h00) | (wr_clr ? TX_CLR_MASK : 8'h00);
  assign next_stat = (stat & ~clr_v) | set_v;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat <= STATUS_RST;
    end else if (run) begin
      stat <= next_stat;
    end
  end

  // ===========================================================================
  // Shared interrupt and Wait wake-up
  logic [7:0] ie;
  logic       irq_req;
  assign ie = {c2[C2_TIE], c2[C2_TX_DONE_IRQ_ENABLE], c2[C2_RIE], c2[C2_IDLE_LINE_IRQ_ENABLE], c2[C2_RIE],
               2'b00, c1[C1_PIE]};
  assign irq_req = |(stat & ie) & !irq_mask;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq <= irq_req;
      wake_req <= irq_req & wait_mode & !halt_mode;
    end
  end

  // ===========================================================================
  // Checks
  AST_PARITY_FRAME: assert property (
    (tx_state == TX_START) && tx_cfg.par_en |->
      ((^(tx_sh & (tx_cfg.word_long ? 9'h1ff : 9'h0ff))) == tx_cfg.par_odd))
    else $error("parity bit gives wrong ones count");
  AST_SCLK_REST: assert property (
    run && (tx_state != TX_DATA) && $past(tx_state) != TX_DATA |=>
      sclk_out == $past(c3[C3_POL]))
    else $error("clock output pulsed outside data bits");
  AST_HIZ: assert property (
    run && !c2[C2_TE] && !c2[C2_RE] |=> txd_oe_n && sclk_oe_n)
    else $error("pins driven with both enables off");
  AST_MASK: assert property (
    irq_mask |=> !irq)
    else $error("interrupt raised while masked");
  AST_OVR_KEEP: assert property (
    rx_done && stat[ST_RXR] |=> stat[ST_OVR] && $stable(rx_buffer))
    else $error("overrun lost the buffered word");
  AST_FE_OVR: assert property (
    rx_done && stat[ST_RXR] && !stat[ST_FE] |=> !stat[ST_FE])
    else $error("framing flag set on overrun");
  AST_HALT: assert property (
    halt_mode |=> $stable(stat) && $stable(tx_state) && $stable(rx_state))
    else $error("state changed during halt");
  AST_TC_NODATA: assert property (
    tx_end && !tx_isdata && !stat[ST_TC] |=> !stat[ST_TC])
    else $error("tx done set after break");
  AST_TXE_LOAD: assert property (
    tx_load |=> stat[ST_TXE] && tx_state == TX_START ##1 !$rose(stat[ST_TXE]))
    else $error("tx empty not set on load");
  AST_WAKE: assert property (
    halt_mode |=> !wake_req)
    else $error("wake request during halt");
  COV_DATA_FRAME: cover property (tx_end && tx_isdata);
  COV_OVERRUN:    cover property (set_v[ST_OVR]);
  COV_PARITY:     cover property (set_v[ST_PE]);
  COV_IDLE:       cover property (set_v[ST_IDLE]);
endmodule

/* File: include/spsc_pkg.sv */
// Constants, types and helpers shared by the serial parity/status/clock block
// =============================================================================
// Summary of operation
// - Frame width follows word length, not parity enable
// - Even parity gives even ones count
// - Odd parity gives odd ones count
// - Parity replaces transmitted data MSB
// - Parity failure sets flag, optional interrupt
// - Address mark uses data MSB, never parity
// - Serial interrupts wake from Wait, not Halt
// - Halt freezes registers and stops transfers
// - Enabled events share one masked interrupt
// - No clock pulses in start/stop bits
// - Last-bit setting gates final data pulse
// - Polarity and phase separately selectable
// - No clock during idle, preamble, break
// - Both enables off floats clock, data pins
// - Tx-empty set on load, cleared by sequence
// - Tx-done after data frames only
// - Rx-ready and errors cleared by sequence
// - Idle flag re-arms only after rx-ready
// - Overrun keeps buffer, overwrites shifter
// - Noise flag raises no own interrupt
// - Framing plus overrun reports overrun only
// - Clock pulse count per frame 7/8/9
// - Polarity sets rest level, phase sets timing
// - Rx interrupt enable also gates overrun interrupt
// - Parity changes apply after current byte
package spsc_pkg;
  // ===========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0]  OFF_STATUS = 8'h00;
  localparam logic [7:0]  OFF_DATA   = 8'h04;
  localparam logic [7:0]  OFF_CTRL1  = 8'h08;
  localparam logic [7:0]  OFF_CTRL2  = 8'h0c;
  localparam logic [7:0]  OFF_CTRL3  = 8'h10;
  localparam logic [7:0]  OFF_BAUD   = 8'h14;
  // Reset values
  localparam logic [7:0]  STATUS_RST = 8'hc0;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [15:0] BAUD_RST   = 16'h0010;
  // Status bit positions
  localparam int ST_TXE = 7, ST_TC = 6, ST_RXR = 5, ST_IDLE = 4;
  localparam int ST_OVR = 3, ST_NF = 2, ST_FE = 1, ST_PE = 0;
  localparam logic [7:0]  TX_CLR_MASK = 8'hc0;
  localparam logic [7:0]  RX_CLR_MASK = 8'h3f;
  // Control one fields
  localparam int C1_RXB8 = 7, C1_TXB8 = 6, C1_LONG = 4;
  localparam int C1_PEN = 2, C1_ODD = 1, C1_PIE = 0;
  // Control two fields
  localparam int C2_TIE = 7, C2_TX_DONE_IRQ_ENABLE = 6, C2_RIE = 5, C2_IDLE_LINE_IRQ_ENABLE = 4;
  localparam int C2_TE = 3, C2_RE = 2, C2_SBK = 0;
  // Control three fields
  localparam int C3_CKEN = 3, C3_POL = 2, C3_PHA = 1, C3_LAST = 0;
  // ===========================================================================
  // Frame settings latched at the start of every frame
  typedef struct packed {
    logic word_long;
    logic par_en;
    logic par_odd;
  } spsc_cfg_t;
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_BRK, TX_START, TX_DATA, TX_STOP}
    spsc_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spsc_rx_t;
  // ===========================================================================
  // Data bits in a frame, parity included
  function automatic logic [3:0] spsc_nbits(input spsc_cfg_t c);
    return c.word_long ? 4'h9 : 4'h8;
  endfunction
  // Parity bit over the 7 or 8 low data bits
  function automatic logic spsc_par(input logic [8:0] w, input spsc_cfg_t c);
    logic [8:0] m;
    m = c.word_long ? 9'h0ff : 9'h07f;
    return (^(w & m)) ^ c.par_odd;
  endfunction
endpackage

/* File: testbench/spsc_peer.sv */
// Far-side model: shift-register receiver, clock edge counter, serial sender
`timescale 1ns/10ps
module spsc_peer (
  input  wire logic hclk,
  input  wire logic txd_out,
  input  wire logic txd_oe_n,
  input  wire logic sclk_out,
  output logic      rxd_pin
);
  localparam int BAUD = 8;
  logic       txd_line;
  logic       sclk_q;
  logic [9:0] cap;
  logic       got;
  int         tog;
  // Pull-up holds the released data line high
  assign txd_line = txd_oe_n ? 1'b1 : txd_out;
  initial begin
    rxd_pin = 1'b1;
    got = 1'b0;
    tog = 0;
    sclk_q = 1'b0;
  end
  // Count every edge seen on the clock output
  always @(posedge hclk) begin
    sclk_q <= sclk_out;
    if (sclk_q !== sclk_out) tog <= tog + 1;
  end
  // Find the start bit and sample ten bits at mid-bit
  always begin
    @(negedge txd_line);
    repeat (BAUD / 2) @(posedge hclk);
    for (int i = 0; i < 10; i++) begin
      repeat (BAUD) @(posedge hclk);
      cap[i] = txd_line;
    end
    got = 1'b1;
  end
  // Send one frame LSB first with a chosen stop level
  task automatic send(input logic [8:0] w, input int n, input logic stop);
    rxd_pin <= 1'b0;
    repeat (BAUD) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      rxd_pin <= w[i];
      repeat (BAUD) @(posedge hclk);
    end
    rxd_pin <= stop;
    repeat (BAUD) @(posedge hclk);
    rxd_pin <= 1'b1;
    repeat (2 * BAUD) @(posedge hclk);
  endtask
endmodule

/* File: testbench/spsc_top_tb_top.sv */
// Self-checking bench for the serial parity, status and clock block
`timescale 1ns/10ps
module spsc_top_tb_top import spsc_pkg::*;;
  localparam int BAUD = 8;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        rxd_pin, txd_out, txd_oe_n, sclk_out, sclk_oe_n;
  logic        irq_mask, halt_mode, wait_mode, irq, wake_req, addr_mark;
  logic        lg, pe, od, lb, pol, pha;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [8:0]  w, a;
  logic [31:0] haddr, hwdata, hrdata, r;
  int          bad_count, n_tests;
  assign hready = hreadyout;
  spsc_top dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxd_pin(rxd_pin), .txd_out(txd_out),
    .txd_oe_n(txd_oe_n), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .irq_mask(irq_mask), .halt_mode(halt_mode), .wait_mode(wait_mode), .irq(irq),
    .wake_req(wake_req), .addr_mark(addr_mark)
  );
  spsc_peer peer_u (
    .hclk(hclk), .txd_out(txd_out), .txd_oe_n(txd_oe_n), .sclk_out(sclk_out),
    .rxd_pin(rxd_pin)
  );
  // ===========================================================================
  // Clock and watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #500_000;
    bad_count++;
    give_verdict();
  end
  // ===========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One AHB single transfer, address phase then data phase
  task automatic xfer(input logic [7:0] ad, input logic is_wr, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, ad};
    htrans <= 2'b10;
    hwrite <= is_wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0000_00, d};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    xfer(ad, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] ad);
    xfer(ad, 1'b0, 8'h00);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // Expected ten samples after the start bit
  function automatic logic [9:0] exp_cap(input logic [8:0] v, input logic l, p, o);
    logic [8:0] f;
    f = v;
    if (p && l) f[8] = (^v[7:0]) ^ o;
    if (p && !l) f[7] = (^v[6:0]) ^ o;
    return l ? {1'b1, f} : {2'b11, f[7:0]};
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ===========================================================================
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, irq_mask, halt_mode, wait_mode} = 6'h00;
    haddr = 0;
    hwdata = 0;
    htrans = 2'b00;
    hsize = 3'b010;
    bad_count = 0;
    n_tests = 0;
    void'($urandom(32'h7e71cb1f));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFF_STATUS);
    chk(r, 32'h0000_00c0, "status reset");
    chk(32'(hresp), 32'h0, "okay response");
    wr(OFF_STATUS, 8'h00);
    rd(OFF_STATUS);
    chk(r, 32'h0000_00c0, "status read only");
    rd(8'h20);
    chk(r, 32'h0000_0000, "unmapped");
    wr(OFF_BAUD, BAUD[7:0]);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      {lb, od, pe, lg} = i[3:0];
      {pol, pha} = 2'($urandom);
      w = 9'($urandom);
      wr(OFF_CTRL2, 8'h00);
      settle(2);
      chk(32'({txd_oe_n, sclk_oe_n}), 32'h3, "pins float");
      wr(OFF_CTRL1, {1'b0, w[8], 1'b0, lg, 1'b0, pe, od, 1'b0});
      wr(OFF_CTRL3, {4'h0, 1'b1, pol, pha, lb});
      settle(3);
      peer_u.tog = 0;
      peer_u.got = 1'b0;
      wr(OFF_CTRL2, 8'h08);
      rd(OFF_STATUS);
      wr(OFF_DATA, w[7:0]);
      for (int k = 0; k < 600 && peer_u.got !== 1'b1; k++) @(posedge hclk);
      chk(32'(peer_u.cap), 32'(exp_cap(w, lg, pe, od)), "frame");
      chk(peer_u.tog, 2 * ((lg ? 8 : 7) + lb), "pulses");
      chk(32'(sclk_out), 32'(pol), "rest level");
      settle(BAUD);
      rd(OFF_STATUS);
      chk(32'(r[7:6]), 32'h3, "tx flags");
    end
    $display("test tx done");
    // Break frames: no clock, no load, no done flag
    peer_u.tog = 0;
    wr(OFF_CTRL2, 8'h09);
    rd(OFF_STATUS);
    wr(OFF_DATA, 8'h5a);
    settle(25 * BAUD);
    rd(OFF_STATUS);
    chk(32'(r[7:6]), 32'h0, "no load or done in break");
    chk(peer_u.tog, 0, "no clock in break");
    $display("test break done");
    wr(OFF_CTRL2, 8'h00);
    wr(OFF_CTRL1, 8'h05);
    wr(OFF_CTRL2, 8'h24);
    w = 9'($urandom);
    peer_u.send({1'b0, ~^w[6:0], w[6:0]}, 8, 1'b1);
    settle(1);
    chk(32'({irq, addr_mark}), 32'({1'b1, w[6]}), "parity irq");
    rd(OFF_STATUS);
    chk(32'({r[5], r[3:0]}), 32'h11, "parity flags");
    rd(OFF_DATA);
    chk(32'(r[6:0]), 32'(w[6:0]), "rx data");
    rd(OFF_STATUS);
    chk(32'({irq, r[5:0]}), 32'h0, "rx cleared");
    settle(15 * BAUD);
    rd(OFF_STATUS);
    chk(32'(r[4]), 32'h1, "idle set");
    rd(OFF_DATA);
    settle(15 * BAUD);
    rd(OFF_STATUS);
    chk(32'(r[4]), 32'h0, "idle not again");
    a = 9'($urandom);
    peer_u.send({1'b0, ^a[6:0], a[6:0]}, 8, 1'b1);
    peer_u.send(9'($urandom), 8, 1'b0);
    rd(OFF_STATUS);
    chk(32'({r[5], r[3], r[1], r[0]}), 32'hc, "overrun only");
    irq_mask <= 1'b1;
    settle(2);
    chk(32'(irq), 32'h0, "masked");
    irq_mask <= 1'b0;
    wait_mode <= 1'b1;
    settle(2);
    chk(32'({irq, wake_req}), 32'h3, "wake");
    halt_mode <= 1'b1;
    settle(2);
    chk(32'(wake_req), 32'h0, "no halt wake");
    {halt_mode, wait_mode} <= 2'b00;
    rd(OFF_DATA);
    chk(32'(r[6:0]), 32'(a[6:0]), "buffer kept");
    $display("test rx done");
    give_verdict();
  end
endmodule
